// ===== rtl/scvc_regs.sv
// Local design decision: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module scvc_regs #(
    parameter int ENTRIES = scvc_pkg::ARB_ENTRIES
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic strap_two_chan_i,
    input wire logic tbl_entry_wr_i,
    input wire logic eeprom_load_i,
    input wire logic [6:0] eeprom_slots_i,
    input wire logic [7:0] eeprom_tc_map_i,
    output scvc_pkg::scvc_ctrl_t ctrl_o,
    output logic table_load_busy_o,
    output logic [$clog2(ENTRIES)-1:0] table_load_idx_o,
    output logic table_load_done_o
);
    logic init_ff;
    logic strap_ff;
    logic [6:0] slots_ff;
    scvc_pkg::scvc_ctrl_t ctrl_ff;
    logic tbl_stat_ff;
    logic [31:0] rdata_ff;
    logic load_start_ff;

    wire logic setup_w = psel_i && !penable_i;
    wire logic access_w = psel_i && penable_i;
    wire logic hit_cap_w = (paddr_i == scvc_pkg::CAP_OFFSET);
    wire logic hit_ctrl_w = (paddr_i == scvc_pkg::CTRL_OFFSET);
    wire logic hit_stat_w = (paddr_i == scvc_pkg::STAT_OFFSET);
    wire logic mapped_w = hit_cap_w || hit_ctrl_w || hit_stat_w;
    wire logic wr_ctrl_w = access_w && pwrite_i && hit_ctrl_w && init_ff;

    // Write-data decode
    wire logic [2:0] wr_sel_w = pwdata_i[scvc_pkg::CTRL_SEL_LSB +: 3];
    wire logic sel_ok_w = (wr_sel_w == scvc_pkg::SEL_DEFAULT) ||
        (wr_sel_w == scvc_pkg::SEL_WRR) ||
        (wr_sel_w == scvc_pkg::SEL_TIME_WRR);
    wire logic [2:0] nxt_sel = sel_ok_w ? wr_sel_w :
        scvc_pkg::SEL_DEFAULT;
    wire logic [7:0] nxt_tc_wr =
        {pwdata_i[scvc_pkg::CTRL_TC_LSB + 1 +: 7], 1'b0};
    wire logic [7:0] nxt_tc_ee = {eeprom_tc_map_i[7:1], 1'b0};
    wire logic load_req_w =
        wr_ctrl_w && pwdata_i[scvc_pkg::CTRL_LOAD_BIT];

    // Capability fields follow the strap caught after reset; max_slots is then replaced by each EEPROM load
    scvc_pkg::scvc_cap_t cap_w;
    wire logic [7:0] arb_cap_w = strap_ff ? scvc_pkg::ARB_CAP_STRAP :
        8'h00;
    wire logic [7:0] tbl_ofs_w = strap_ff ? scvc_pkg::TBL_OFS_STRAP :
        8'h00;
    assign cap_w = '{table_offset: tbl_ofs_w, max_slots: slots_ff,
        arb_cap: arb_cap_w};

    wire logic [31:0] cap_word_w =
        ({24'h000000, cap_w.arb_cap} << scvc_pkg::CAP_ARB_LSB) |
        ({25'h0000000, cap_w.max_slots} << scvc_pkg::CAP_SLOTS_LSB) |
        ({24'h000000, cap_w.table_offset} << scvc_pkg::CAP_TBL_OFS_LSB);
    // Bits 14, 15 and every reserved range stay zero

    wire logic [31:0] ctrl_word_w =
        ({24'h000000, ctrl_ff.traffic_class_channel_map}
            << scvc_pkg::CTRL_TC_LSB) |
        ({29'h00000000, ctrl_ff.arb_select} << scvc_pkg::CTRL_SEL_LSB) |
        ({29'h00000000, ctrl_ff.channel_identifier}
            << scvc_pkg::CTRL_ID_LSB) |
        ({31'h00000000, ctrl_ff.enable} << scvc_pkg::CTRL_EN_BIT);
    // Load bit is never stored, so it reads zero

    wire logic [31:0] stat_word_w =
        {31'h00000000, tbl_stat_ff} << scvc_pkg::STAT_TBL_BIT;

    wire logic [31:0] rd_mux_w = hit_cap_w ? cap_word_w :
        hit_ctrl_w ? ctrl_word_w :
        hit_stat_w ? stat_word_w : 32'h00000000;

    // Strap is sampled one edge after release, never under reset
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            init_ff <= 1'b0;
            strap_ff <= 1'b0;
        end else if (!init_ff) begin
            init_ff <= 1'b1;
            strap_ff <= strap_two_chan_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slots_ff <= 7'h00;
        end else if (!init_ff) begin
            slots_ff <= strap_two_chan_i ? scvc_pkg::SLOTS_STRAP :
                7'h00;
        end else if (eeprom_load_i) begin
            slots_ff <= eeprom_slots_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_ff <= '0;
        end else if (!init_ff) begin
            ctrl_ff.channel_identifier <= strap_two_chan_i ?
                scvc_pkg::CHAN_ID_STRAP : 3'h0;
            ctrl_ff.traffic_class_channel_map <= scvc_pkg::TC_MAP_RESET;
        end else if (wr_ctrl_w) begin
            ctrl_ff.traffic_class_channel_map <= nxt_tc_wr;
            ctrl_ff.arb_select <= nxt_sel;
            ctrl_ff.channel_identifier <=
                pwdata_i[scvc_pkg::CTRL_ID_LSB +: 3];
            ctrl_ff.enable <= pwdata_i[scvc_pkg::CTRL_EN_BIT];
        end else if (eeprom_load_i) begin
            ctrl_ff.traffic_class_channel_map <= nxt_tc_ee;
        end
    end

    // Set beats clear: an entry write racing the load end keeps the flag
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tbl_stat_ff <= 1'b0;
        end else if (tbl_entry_wr_i) begin
            tbl_stat_ff <= 1'b1;
        end else if (table_load_done_o) begin
            tbl_stat_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_start_ff <= 1'b0;
        end else begin
            load_start_ff <= load_req_w;
        end
    end

    // Read data is latched in setup so it comes from a flop with no wait
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_ff <= 32'h00000000;
        end else if (setup_w && !pwrite_i) begin
            rdata_ff <= rd_mux_w;
        end
    end

    scvc_load_seq #(
        .ENTRIES(ENTRIES)
    ) u_load_seq (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .start_i(load_start_ff),
        .busy_o(table_load_busy_o),
        .idx_o(table_load_idx_o),
        .done_o(table_load_done_o)
    );

    assign prdata_o = rdata_ff;
    assign pready_o = 1'b1;
    assign pslverr_o = access_w && !mapped_w;
    assign ctrl_o = ctrl_ff;

    chk_cap_arb_field: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) init_ff && setup_w && !pwrite_i && hit_cap_w
        |=> prdata_o[7:0] == (strap_ff ? 8'h19 : 8'h00))
        else $error("arbitration capability value wrong");

    chk_strap_capture: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) $rose(init_ff) |->
        strap_ff == $past(strap_two_chan_i))
        else $error("strap not captured after reset");

    chk_cap_slots: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) $rose(init_ff) && !eeprom_load_i |=>
        cap_word_w[22:16] == (strap_ff ? 7'h7f : 7'h00))
        else $error("time slot reset value wrong");

    chk_slots_autoload: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) init_ff && eeprom_load_i |=>
        cap_word_w[22:16] == $past(eeprom_slots_i))
        else $error("time slot autoload not taken");

    chk_cap_offset: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) init_ff && setup_w && !pwrite_i && hit_cap_w
        |=> prdata_o[31:24] == (strap_ff ? 8'h08 : 8'h00))
        else $error("table offset value wrong");

    chk_cap_read_only: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        init_ff && access_w && pwrite_i && hit_cap_w && !eeprom_load_i |=>
        $stable(cap_word_w))
        else $error("capability changed by a write");

    chk_cap_zero_bits: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        cap_word_w[15:8] == 8'h00 && cap_word_w[23] == 1'b0)
        else $error("capability reserved or fixed bit set");

    chk_cap_rsvd_read: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) setup_w && !pwrite_i && hit_cap_w |=>
        prdata_o[15:8] == 8'h00 && prdata_o[23] == 1'b0)
        else $error("capability read shows reserved bit");

    chk_tc_map_write: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) wr_ctrl_w |=>
        ctrl_o.traffic_class_channel_map ==
        {$past(pwdata_i[7:1]), 1'b0})
        else $error("traffic class map not written");

    chk_tc_autoload: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) init_ff && eeprom_load_i && !wr_ctrl_w |=>
        ctrl_o.traffic_class_channel_map ==
        {$past(eeprom_tc_map_i[7:1]), 1'b0})
        else $error("class map autoload not taken");

    chk_tc_bit_zero: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        ctrl_o.traffic_class_channel_map[0] == 1'b0)
        else $error("class zero mapped on this channel");

    chk_load_start: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) load_req_w && !table_load_busy_o |=>
        ##1 table_load_busy_o)
        else $error("table load did not start");

    chk_load_idx_start: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) $rose(table_load_busy_o) |->
        table_load_idx_o == '0)
        else $error("table load index does not start at zero");

    // Counts busy cycles of a load; only the length check reads it
    logic [$clog2(ENTRIES):0] busy_len_ff;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_len_ff <= '0;
        end else if (table_load_busy_o) begin
            busy_len_ff <= busy_len_ff + 1'b1;
        end else begin
            busy_len_ff <= '0;
        end
    end

    chk_load_length: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) $fell(table_load_busy_o) |->
        table_load_done_o &&
        int'(busy_len_ff) == ENTRIES)
        else $error("table load length wrong");

    chk_ctrl_rsvd_read: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) setup_w && !pwrite_i && hit_ctrl_w |=>
        prdata_o[16] == 1'b0 && prdata_o[15:8] == 8'h00 &&
        prdata_o[23:20] == 4'h0 && prdata_o[30:27] == 4'h0)
        else $error("control read shows load or reserved bit");

    chk_sel_legal: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) wr_ctrl_w && !sel_ok_w |=>
        ctrl_o.arb_select == 3'h0)
        else $error("illegal select value kept");

    chk_sel_kept: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) wr_ctrl_w && sel_ok_w |=>
        ctrl_o.arb_select == $past(wr_sel_w))
        else $error("legal select value not stored");

    chk_chan_id_init: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) $rose(init_ff) |->
        ctrl_o.channel_identifier == (strap_ff ? 3'h1 : 3'h0) &&
        !ctrl_o.enable)
        else $error("channel identifier or enable reset wrong");

    chk_id_write: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) wr_ctrl_w |=>
        ctrl_o.channel_identifier == $past(pwdata_i[26:24]))
        else $error("channel identifier not written");

    chk_enable_write: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) wr_ctrl_w |=>
        ctrl_o.enable == $past(pwdata_i[31]))
        else $error("enable bit not written");

    chk_ctrl_hold: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) init_ff && !wr_ctrl_w && !eeprom_load_i |=>
        $stable(ctrl_o))
        else $error("control changed without a write");

    chk_tbl_status: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (tbl_entry_wr_i |=> tbl_stat_ff) and
        (table_load_done_o && !tbl_entry_wr_i |=> !tbl_stat_ff))
        else $error("table status flag wrong");

endmodule
`default_nettype wire

// ===== shared/scvc_pkg.sv
`default_nettype none
package scvc_pkg;

    localparam logic [11:0] CAP_OFFSET = 12'h15c;
    localparam logic [11:0] CTRL_OFFSET = 12'h160;
    localparam logic [11:0] STAT_OFFSET = 12'h164;

    // Capability register field positions
    localparam int CAP_ARB_LSB = 0;
    localparam int CAP_ADV_SW_BIT = 14;
    localparam int CAP_SNOOP_BIT = 15;
    localparam int CAP_SLOTS_LSB = 16;
    localparam int CAP_TBL_OFS_LSB = 24;

    // Control register field positions
    localparam int CTRL_TC_LSB = 0;
    localparam int CTRL_LOAD_BIT = 16;
    localparam int CTRL_SEL_LSB = 17;
    localparam int CTRL_ID_LSB = 24;
    localparam int CTRL_EN_BIT = 31;

    localparam int STAT_TBL_BIT = 16;

    // Values after reset; all but TC_MAP_RESET depend on the strap
    localparam logic [7:0] ARB_CAP_STRAP = 8'h19;
    localparam logic [6:0] SLOTS_STRAP = 7'h7f;
    localparam logic [7:0] TBL_OFS_STRAP = 8'h08;
    localparam logic [2:0] CHAN_ID_STRAP = 3'h1;
    localparam logic [7:0] TC_MAP_RESET = 8'h00;

    // Port arbitration select encodings
    localparam logic [2:0] SEL_DEFAULT = 3'h0;
    localparam logic [2:0] SEL_WRR = 3'h3;
    localparam logic [2:0] SEL_TIME_WRR = 3'h4;

    localparam int ARB_ENTRIES = 128;

    typedef struct packed {
        logic enable;
        logic [2:0] channel_identifier;
        logic [2:0] arb_select;
        logic [7:0] traffic_class_channel_map;
    } scvc_ctrl_t;

    typedef struct packed {
        logic [7:0] table_offset;
        logic [6:0] max_slots;
        logic [7:0] arb_cap;
    } scvc_cap_t;

endpackage
`default_nettype wire

// ===== rtl/scvc_load_seq.sv
`timescale 1ns/1ns
`default_nettype none
module scvc_load_seq #(
    parameter int ENTRIES = scvc_pkg::ARB_ENTRIES
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    output logic busy_o,
    output logic [$clog2(ENTRIES)-1:0] idx_o,
    output logic done_o
);
    typedef enum logic {SCVC_IDLE, SCVC_LOAD} scvc_seq_t;

    localparam logic [$clog2(ENTRIES)-1:0] LAST_IDX =
        ($clog2(ENTRIES))'(ENTRIES - 1);

    scvc_seq_t state_ff;
    scvc_seq_t nxt_state;
    logic [$clog2(ENTRIES)-1:0] idx_ff;
    logic done_ff;
    wire logic last_w = (idx_ff == LAST_IDX);

    // A request during a load is absorbed; the load already uses new table
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SCVC_IDLE: begin
                if (start_i) begin
                    nxt_state = SCVC_LOAD;
                end
            end
            SCVC_LOAD: begin
                if (last_w) begin
                    nxt_state = SCVC_IDLE;
                end
            end
            default: nxt_state = SCVC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= SCVC_IDLE;
            idx_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            idx_ff <= (state_ff == SCVC_LOAD) ? idx_ff + 1'b1 : '0;
            done_ff <= (state_ff == SCVC_LOAD) && last_w;
        end
    end

    assign busy_o = (state_ff == SCVC_LOAD);
    assign idx_o = idx_ff;
    assign done_o = done_ff;
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int ENT = 4;
    logic core_clk, rst_n, psel, penable, pwrite, strap, tbl_wr, ee_ld;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, err, busy, done;
    logic [6:0] ee_slots;
    logic [7:0] ee_map;
    logic [$clog2(ENT)-1:0] idx;
    scvc_pkg::scvc_ctrl_t ctrl;
    int n_fail, checked, n, k;

    scvc_regs #(.ENTRIES(ENT)) dut (
        .core_clk_i(core_clk), .rst_n_i(rst_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .strap_two_chan_i(strap),
        .tbl_entry_wr_i(tbl_wr), .eeprom_load_i(ee_ld),
        .eeprom_slots_i(ee_slots), .eeprom_tc_map_i(ee_map),
        .ctrl_o(ctrl), .table_load_busy_o(busy),
        .table_load_idx_o(idx), .table_load_done_o(done)
    );

    always #25 core_clk = ~core_clk;

    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Master waits on pready itself, no fixed latency assumed
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset(input logic s);
        strap <= s;
        rst_n <= 1'b0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
    endtask

    task automatic pulse_in(input bit tbl);
        @(posedge core_clk);
        if (tbl) tbl_wr <= 1'b1;
        else ee_ld <= 1'b1;
        @(posedge core_clk);
        tbl_wr <= 1'b0;
        ee_ld <= 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        close_out();
    end

    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        {psel, penable, pwrite, strap, tbl_wr, ee_ld} = '0;
        paddr = '0;
        pwdata = '0;
        ee_slots = '0;
        ee_map = '0;
        n_fail = 0;
        checked = 0;
        do_reset(1'b1);
        apb(1'b0, 12'h15c, 32'h0);
        chk("cap reset", rd, 32'h087f0019);
        chk("arb schemes", {24'h0, rd[7:0]}, 32'h19);
        apb(1'b0, 12'h160, 32'h0);
        chk("ctrl reset", rd, 32'h01000000);
        $display("test reset values done");

        ee_slots <= 7'h12;
        ee_map <= 8'hab;
        pulse_in(1'b0);
        apb(1'b0, 12'h15c, 32'h0);
        chk("cap autoload", rd, 32'h08120019);
        apb(1'b0, 12'h160, 32'h0);
        chk("ctrl autoload", rd, 32'h010000aa);
        $display("test autoload done");

        // All ones touches reserved, load, illegal select at once
        apb(1'b1, 12'h160, 32'hffffffff);
        apb(1'b0, 12'h160, 32'h0);
        chk("ctrl all ones", rd, 32'h870000fe);
        chk("ctrl port", {17'h0, ctrl}, 32'h000078fe);
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, 12'h160, {12'h0, 3'(s), 17'h0});
            apb(1'b0, 12'h160, 32'h0);
            n = (s == 0 || s == 3 || s == 4) ? s : 0;
            chk("select", rd, {12'h0, 3'(n), 17'h0});
            chk("select port", {29'h0, ctrl.arb_select}, 32'(n));
        end
        $display("test control fields done");

        apb(1'b1, 12'h15c, 32'hffffffff);
        chk("cap write err", {31'h0, err}, 32'h0);
        apb(1'b0, 12'h15c, 32'h0);
        chk("cap after write", rd, 32'h08120019);
        apb(1'b0, 12'h168, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        apb(1'b1, 12'h168, 32'h0);
        chk("unmapped wr err", {31'h0, err}, 32'h1);
        $display("test refused access done");

        pulse_in(1'b1);
        apb(1'b0, 12'h164, 32'h0);
        chk("status set", rd, 32'h00010000);
        apb(1'b1, 12'h160, 32'h00010000);
        n = 0;
        k = 0;
        while (done !== 1'b1 && k < 40) begin
            @(posedge core_clk);
            if (busy === 1'b1) begin
                chk("load index", 32'(idx), 32'(n));
                n++;
            end
            k++;
        end
        chk("load done", {31'h0, done}, 32'h1);
        chk("load length", 32'(n), 32'(ENT));
        apb(1'b0, 12'h164, 32'h0);
        chk("status clear", rd, 32'h0);
        apb(1'b0, 12'h160, 32'h0);
        chk("load reads zero", rd, 32'h0);
        $display("test table load done");

        // Second reset mid-run, strap low this time
        do_reset(1'b0);
        apb(1'b0, 12'h15c, 32'h0);
        chk("cap strap low", rd, 32'h0);
        apb(1'b0, 12'h160, 32'h0);
        chk("ctrl strap low", rd, 32'h0);
        chk("port strap low", {17'h0, ctrl}, 32'h0);
        $display("test strap low done");
        close_out();
    end
endmodule
`default_nettype wire
